//--- crxm_defs.vh
/*
  register map, field positions, reset values and counts for the receive
  management and delay register bank.
  assumes: included by bare name from the design files of this block.
*/
`ifndef CRXM_DEFS_VH
`define CRXM_DEFS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CRXM_ADDR_W 8
`define CRXM_OFF_MGMT_STATUS 8'h2c
`define CRXM_OFF_DELAY_CTRL 8'h30
`define CRXM_OFF_FILL_STATUS 8'h34
`define CRXM_OFF_ROUND_TRIP 8'h38
`define CRXM_OFF_EXT_SETUP 8'h3c
`define CRXM_OFF_MGMT_SETUP 8'h44
`define CRXM_OFF_IRQ_STATUS 8'h50
`define CRXM_OFF_IRQ_MASK 8'h54

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CRXM_STAT_SPEED_LSB 8
`define CRXM_STAT_SPEED_OK 11
`define CRXM_STAT_PTR_OK 6
`define CRXM_CTRL_RESYNC 16
`define CRXM_SETUP_SPEED_LSB 8
`define CRXM_SETUP_LOAD_SPEED 16
`define CRXM_SETUP_LOAD_PTR 17
`define CRXM_RT_W 20
`define CRXM_EXT_W 9
`define CRXM_SPEED_W 3
`define CRXM_PTR_W 6

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define CRXM_IRQ_W 4
`define CRXM_IRQ_SPEED 0
`define CRXM_IRQ_PTR 1
`define CRXM_IRQ_RT 2
`define CRXM_IRQ_RESYNC 3

// ----------------------------------------------------------------
// codes, limits and reset values
// ----------------------------------------------------------------
`define CRXM_SPEED_NONE 3'h0
`define CRXM_SPEED_240 3'h1
`define CRXM_SPEED_480 3'h2
`define CRXM_SPEED_960 3'h3
`define CRXM_SPEED_1920 3'h4
`define CRXM_SPEED_2400 3'h5
`define CRXM_PTR_MIN 6'h24
`define CRXM_PTR_MAX 6'h3f
`define CRXM_ACCEPT_COUNT 3'h4
`define CRXM_RST_SPEED 3'h0
`define CRXM_RST_PTR 6'h0
`define CRXM_RST_EXT 9'h000

`endif

//--- crxm_accept.v
/*
  acceptance filter: a new value from a control byte is taken only after
  the same value was seen in a row of hyperframes; software may load one.
  assumes: hf_i is a one-cycle pulse, data_i is stable with it.
*/
`timescale 1ns/1ps
`include "crxm_defs.vh"

module crxm_accept #(
  parameter W = 3
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire hf_i,
  input wire [W-1:0] data_i,
  input wire ok_i,
  input wire load_i,
  input wire [W-1:0] load_data_i,
  input wire load_ok_i,
  output reg [W-1:0] acc_o,
  output reg valid_o,
  output reg new_o
);

  reg [W-1:0] cand_ff;
  reg [2:0] cnt_ff;
  wire [2:0] cnt_inc;

  assign cnt_inc = cnt_ff + 3'h1;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cand_ff <= {W{1'b0}};
      cnt_ff <= 3'h0;
      acc_o <= {W{1'b0}};
      valid_o <= 1'b0;
      new_o <= 1'b0;
    end else begin
      new_o <= 1'b0;
      if (load_i && load_ok_i) begin
        // set-up load overrides and restarts the filter
        acc_o <= load_data_i;
        valid_o <= 1'b1;
        new_o <= 1'b1;
        cnt_ff <= 3'h0;
      end else if (hf_i) begin
        if (!ok_i || (valid_o && data_i == acc_o)) begin
          cnt_ff <= 3'h0;
        end else if (cnt_ff != 3'h0 && data_i == cand_ff) begin
          if (cnt_inc == `CRXM_ACCEPT_COUNT) begin
            acc_o <= data_i;
            valid_o <= 1'b1;
            new_o <= 1'b1;
            cnt_ff <= 3'h0;
          end else begin
            cnt_ff <= cnt_inc;
          end
        end else begin
          cand_ff <= data_i;
          cnt_ff <= 3'h1;
        end
      end
    end
  end

endmodule // crxm_accept

//--- crxm_regs.v
/*
  receive management and delay register bank: accepted hdlc speed and
  ethernet pointer, elastic buffer delay control and status, round trip
  measurement, extended measurement period, and an interrupt block.
  assumes: plain register port with read data one cycle after the read
  strobe; framer supplies hyperframe pulse, control bytes, radio frame
  pulses and buffer status synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "crxm_defs.vh"

module crxm_regs #(
  parameter BUF_W = 6
) (
  input wire clk_i,
  input wire sys_rst_i,
  // register port
  input wire [`CRXM_ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [31:0] reg_rdata_o,
  // control bytes from the receive framer
  input wire hyperframe_i,
  input wire [2:0] hdlc_speed_byte_i,
  input wire [5:0] eth_pointer_byte_i,
  // elastic buffer
  input wire [BUF_W-1:0] buf_fill_i,
  input wire [1:0] byte_delay_i,
  output wire buf_realign_o,
  output wire [BUF_W-1:0] buf_init_delay_o,
  // radio frame pulses
  input wire tx_frame_pulse_i,
  input wire rx_frame_pulse_i,
  // accepted values and settings to the rest of the core
  output wire [2:0] accepted_hdlc_speed_o,
  output wire hdlc_speed_ok_flag_o,
  output wire [5:0] accepted_eth_pointer_o,
  output wire eth_pointer_ok_flag_o,
  output wire [8:0] ext_measure_period_o,
  output wire irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // code 0 means no channel, yet still counts as a valid setting
  function speed_ok;
    input [2:0] code;
    begin
      case (code)
        `CRXM_SPEED_NONE,
        `CRXM_SPEED_240,
        `CRXM_SPEED_480,
        `CRXM_SPEED_960,
        `CRXM_SPEED_1920,
        `CRXM_SPEED_2400: speed_ok = 1'b1;
        default: speed_ok = 1'b0;
      endcase
    end
  endfunction

  function ptr_ok;
    input [5:0] ptr;
    begin
      ptr_ok = (ptr >= `CRXM_PTR_MIN) && (ptr <= `CRXM_PTR_MAX);
    end
  endfunction

  function sel;
    input [`CRXM_ADDR_W-1:0] addr;
    input [`CRXM_ADDR_W-1:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  // half depth, the reset value of the initial delay
  localparam [BUF_W-1:0] INIT_DELAY_RST = {1'b1, {(BUF_W-1){1'b0}}};

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr_ctrl;
  wire wr_ext;
  wire wr_setup;
  wire wr_irq_stat;
  wire wr_irq_mask;

  // set-up offset is write-only: it loads the filters and stores nothing
  assign wr_ctrl = reg_wr_i && sel(reg_addr_i, `CRXM_OFF_DELAY_CTRL);
  assign wr_ext = reg_wr_i && sel(reg_addr_i, `CRXM_OFF_EXT_SETUP);
  assign wr_setup = reg_wr_i && sel(reg_addr_i, `CRXM_OFF_MGMT_SETUP);
  assign wr_irq_stat = reg_wr_i && sel(reg_addr_i, `CRXM_OFF_IRQ_STATUS);
  assign wr_irq_mask = reg_wr_i && sel(reg_addr_i, `CRXM_OFF_IRQ_MASK);

  // ----------------------------------------------------------------
  // accepted hdlc speed and ethernet pointer
  // ----------------------------------------------------------------
  wire speed_new;
  wire ptr_new;
  wire [2:0] setup_speed;
  wire [5:0] setup_ptr;
  wire load_speed;
  wire load_ptr;
  wire byte_speed_ok;
  wire byte_ptr_ok;

  assign setup_speed = reg_wdata_i[`CRXM_SETUP_SPEED_LSB +: `CRXM_SPEED_W];
  assign setup_ptr = reg_wdata_i[`CRXM_PTR_W-1:0];
  assign load_speed = wr_setup && reg_wdata_i[`CRXM_SETUP_LOAD_SPEED];
  assign load_ptr = wr_setup && reg_wdata_i[`CRXM_SETUP_LOAD_PTR];
  // out-of-range codes break a run, so a glitched byte restarts the count
  assign byte_speed_ok = speed_ok(hdlc_speed_byte_i);
  assign byte_ptr_ok = ptr_ok(eth_pointer_byte_i);

  // four matching hyperframes or a set-up load
  crxm_accept #(
    .W(`CRXM_SPEED_W)
  ) u_speed (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .hf_i(hyperframe_i),
    .data_i(hdlc_speed_byte_i),
    .ok_i(byte_speed_ok),
    .load_i(load_speed),
    .load_data_i(setup_speed),
    .load_ok_i(speed_ok(setup_speed)),
    .acc_o(accepted_hdlc_speed_o),
    .valid_o(hdlc_speed_ok_flag_o),
    .new_o(speed_new)
  );

  crxm_accept #(
    .W(`CRXM_PTR_W)
  ) u_ptr (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .hf_i(hyperframe_i),
    .data_i(eth_pointer_byte_i),
    .ok_i(byte_ptr_ok),
    .load_i(load_ptr),
    .load_data_i(setup_ptr),
    .load_ok_i(ptr_ok(setup_ptr)),
    .acc_o(accepted_eth_pointer_o),
    .valid_o(eth_pointer_ok_flag_o),
    .new_o(ptr_new)
  );

  // ----------------------------------------------------------------
  // delay control and realignment
  // ----------------------------------------------------------------
  reg resync_ff;
  reg [BUF_W-1:0] init_delay_ff;
  reg [8:0] ext_period_ff;
  reg realign_done_ff;
  reg realign_ff;
  reg [BUF_W-1:0] buf_delay_ff;

  // writing the delay with bit 16 low only stores it
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      resync_ff <= 1'b0;
      init_delay_ff <= INIT_DELAY_RST;
      realign_ff <= 1'b0;
      buf_delay_ff <= INIT_DELAY_RST;
      realign_done_ff <= 1'b0;
    end else begin
      realign_ff <= 1'b0;
      realign_done_ff <= realign_ff;
      if (wr_ctrl) begin
        resync_ff <= reg_wdata_i[`CRXM_CTRL_RESYNC];
        init_delay_ff <= reg_wdata_i[BUF_W-1:0];
        if (reg_wdata_i[`CRXM_CTRL_RESYNC]) begin
          // new delay reaches the buffer only with the realign pulse
          realign_ff <= 1'b1;
          buf_delay_ff <= reg_wdata_i[BUF_W-1:0];
        end
      end
    end
  end

  // buffer side keeps its delay until the next realign
  assign buf_realign_o = realign_ff;
  assign buf_init_delay_o = buf_delay_ff;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_period_ff <= `CRXM_RST_EXT;
    end else if (wr_ext) begin
      ext_period_ff <= reg_wdata_i[`CRXM_EXT_W-1:0];
    end
  end

  assign ext_measure_period_o = ext_period_ff;

  // ----------------------------------------------------------------
  // round trip measurement
  // ----------------------------------------------------------------
  // counter saturates so a lost receive pulse cannot wrap to a short value
  reg rt_run_ff;
  reg [`CRXM_RT_W-1:0] rt_cnt_ff;
  reg [`CRXM_RT_W-1:0] rt_result_ff;
  reg rt_done_ff;
  wire rt_max;
  wire [`CRXM_RT_W-1:0] rt_cnt_inc;

  assign rt_max = &rt_cnt_ff;
  // held at all ones once full, the stored result as well
  assign rt_cnt_inc = rt_max ? rt_cnt_ff : rt_cnt_ff + {{(`CRXM_RT_W-1){1'b0}}, 1'b1};

  // a receive pulse with no measurement running is ignored
  // a new transmit pulse restarts the count

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rt_run_ff <= 1'b0;
      rt_cnt_ff <= {`CRXM_RT_W{1'b0}};
      rt_result_ff <= {`CRXM_RT_W{1'b0}};
      rt_done_ff <= 1'b0;
    end else begin
      rt_done_ff <= 1'b0;
      if (tx_frame_pulse_i) begin
        rt_run_ff <= 1'b1;
        rt_cnt_ff <= {`CRXM_RT_W{1'b0}};
      end else if (rt_run_ff && rx_frame_pulse_i) begin
        rt_run_ff <= 1'b0;
        rt_result_ff <= rt_cnt_inc;
        rt_done_ff <= 1'b1;
      end else if (rt_run_ff && !rt_max) begin
        rt_cnt_ff <= rt_cnt_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  reg [`CRXM_IRQ_W-1:0] irq_stat_ff;
  reg [`CRXM_IRQ_W-1:0] irq_mask_ff;
  wire [`CRXM_IRQ_W-1:0] irq_set;
  wire [`CRXM_IRQ_W-1:0] irq_clr;
  reg [`CRXM_IRQ_W-1:0] nxt_irq_stat;

  assign irq_set = {realign_done_ff, rt_done_ff, ptr_new, speed_new};
  assign irq_clr = wr_irq_stat ? reg_wdata_i[`CRXM_IRQ_W-1:0] : {`CRXM_IRQ_W{1'b0}};

  // a set in the clearing cycle wins, so no event is lost to a clear
  always @* begin
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  end

  // status bits are sticky until software writes a one to them
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_stat_ff <= {`CRXM_IRQ_W{1'b0}};
      irq_mask_ff <= {`CRXM_IRQ_W{1'b0}};
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_irq_mask) begin
        irq_mask_ff <= reg_wdata_i[`CRXM_IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // only mapped offsets answer; the set-up register reads as zero
  reg [31:0] nxt_rdata;
  reg [31:0] rdata_ff;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr_i)
      `CRXM_OFF_MGMT_STATUS: begin
        nxt_rdata[`CRXM_STAT_SPEED_LSB +: `CRXM_SPEED_W] = accepted_hdlc_speed_o;
        nxt_rdata[`CRXM_STAT_SPEED_OK] = hdlc_speed_ok_flag_o;
        nxt_rdata[`CRXM_STAT_PTR_OK] = eth_pointer_ok_flag_o;
        nxt_rdata[`CRXM_PTR_W-1:0] = accepted_eth_pointer_o;
      end
      `CRXM_OFF_DELAY_CTRL: begin
        // resync reads back as last written
        nxt_rdata[`CRXM_CTRL_RESYNC] = resync_ff;
        nxt_rdata[BUF_W-1:0] = init_delay_ff;
      end
      `CRXM_OFF_FILL_STATUS: begin
        nxt_rdata[BUF_W+1:2] = buf_fill_i;
        nxt_rdata[1:0] = byte_delay_i;
      end
      `CRXM_OFF_ROUND_TRIP: begin
        nxt_rdata[`CRXM_RT_W-1:0] = rt_result_ff;
      end
      `CRXM_OFF_EXT_SETUP: begin
        nxt_rdata[`CRXM_EXT_W-1:0] = ext_period_ff;
      end
      `CRXM_OFF_IRQ_STATUS: begin
        nxt_rdata[`CRXM_IRQ_W-1:0] = irq_stat_ff;
      end
      `CRXM_OFF_IRQ_MASK: begin
        nxt_rdata[`CRXM_IRQ_W-1:0] = irq_mask_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // data stands only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_ff;

endmodule // crxm_regs

//--- crxm_regs_sva.sv
/* assertions on the register port and accepted values of crxm_regs.
   assumes: bound to crxm_regs, one clock, synchronous reset. */
`timescale 1ns/1ps
`include "crxm_defs.vh"

module crxm_regs_sva #(
  parameter BUF_W = 6
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [`CRXM_ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire hyperframe_i,
  input wire [2:0] hdlc_speed_byte_i,
  input wire [5:0] eth_pointer_byte_i,
  input wire [BUF_W-1:0] buf_fill_i,
  input wire [1:0] byte_delay_i,
  input wire buf_realign_o,
  input wire [BUF_W-1:0] buf_init_delay_o,
  input wire [2:0] accepted_hdlc_speed_o,
  input wire hdlc_speed_ok_flag_o,
  input wire [5:0] accepted_eth_pointer_o,
  input wire eth_pointer_ok_flag_o,
  input wire [8:0] ext_measure_period_o
);
  // ----------------------------------------
  // runs of identical control bytes
  // ----------------------------------------
  reg [1:0] spd_run_ff;
  reg [1:0] ptr_run_ff;
  reg [2:0] spd_last_ff;
  reg [5:0] ptr_last_ff;
  wire spd_same = hdlc_speed_byte_i == spd_last_ff && spd_run_ff != 2'h0;
  wire ptr_same = eth_pointer_byte_i == ptr_last_ff && ptr_run_ff != 2'h0;
  wire spd_4th = hyperframe_i && spd_same && spd_run_ff == 2'h3;
  wire ptr_4th = hyperframe_i && ptr_same && ptr_run_ff == 2'h3;
  wire set_wr = reg_wr_i && reg_addr_i == `CRXM_OFF_MGMT_SETUP;
  wire ctl_wr = reg_wr_i && reg_addr_i == `CRXM_OFF_DELAY_CTRL;

  // count saturates at three: every matching pulse from the fourth on matters
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      spd_run_ff <= 2'h0;
      ptr_run_ff <= 2'h0;
    end else if (hyperframe_i) begin
      spd_last_ff <= hdlc_speed_byte_i;
      ptr_last_ff <= eth_pointer_byte_i;
      spd_run_ff <= spd_same ? spd_run_ff + {1'b0, spd_run_ff != 2'h3} : 2'h1;
      ptr_run_ff <= ptr_same ? ptr_run_ff + {1'b0, ptr_run_ff != 2'h3} : 2'h1;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_spd_cause;
    $changed(accepted_hdlc_speed_o) || $rose(hdlc_speed_ok_flag_o) |->
      $past(spd_4th) || $past(set_wr && reg_wdata_i[`CRXM_SETUP_LOAD_SPEED]);
  endproperty
  a_spd_cause: assert property (p_spd_cause) else $error("speed taken early");
  property p_ptr_cause;
    $changed(accepted_eth_pointer_o) || $rose(eth_pointer_ok_flag_o) |->
      $past(ptr_4th) || $past(set_wr && reg_wdata_i[`CRXM_SETUP_LOAD_PTR]);
  endproperty
  a_ptr_cause: assert property (p_ptr_cause) else $error("pointer taken early");
  property p_spd_range;
    hdlc_speed_ok_flag_o |-> accepted_hdlc_speed_o <= `CRXM_SPEED_2400;
  endproperty
  a_spd_range: assert property (p_spd_range) else $error("bad speed code");
  property p_ptr_range;
    eth_pointer_ok_flag_o |-> accepted_eth_pointer_o >= `CRXM_PTR_MIN;
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
  property p_flag_hold;
    hdlc_speed_ok_flag_o |=> hdlc_speed_ok_flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("speed flag dropped");
  property p_status_rd;
    reg_rd_i && reg_addr_i == `CRXM_OFF_MGMT_STATUS |=> reg_rdata_o == {20'h0,
      $past(hdlc_speed_ok_flag_o), $past(accepted_hdlc_speed_o), 1'b0,
      $past(eth_pointer_ok_flag_o), $past(accepted_eth_pointer_o)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");
  property p_realign;
    ctl_wr && reg_wdata_i[`CRXM_CTRL_RESYNC] |=> buf_realign_o &&
      buf_init_delay_o == $past(reg_wdata_i[BUF_W-1:0]);
  endproperty
  a_realign: assert property (p_realign) else $error("realign missing");
  property p_delay_hold;
    $changed(buf_init_delay_o) || buf_realign_o |->
      $past(ctl_wr && reg_wdata_i[`CRXM_CTRL_RESYNC]);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay moved alone");
  property p_delay_rst;
    $fell(sys_rst_i) |-> buf_init_delay_o == {1'b1, {(BUF_W-1){1'b0}}};
  endproperty
  a_delay_rst: assert property (p_delay_rst) else $error("delay reset wrong");
  property p_fill_rd;
    reg_rd_i && reg_addr_i == `CRXM_OFF_FILL_STATUS |=>
      reg_rdata_o == {{(30-BUF_W){1'b0}}, $past(buf_fill_i), $past(byte_delay_i)};
  endproperty
  a_fill_rd: assert property (p_fill_rd) else $error("fill read wrong");
  property p_ext_wr;
    reg_wr_i && reg_addr_i == `CRXM_OFF_EXT_SETUP |=>
      ext_measure_period_o == $past(reg_wdata_i[8:0]);
  endproperty
  a_ext_wr: assert property (p_ext_wr) else $error("period not stored");

  c_spd: cover property (spd_4th);
  c_realign: cover property (ctl_wr && reg_wdata_i[`CRXM_CTRL_RESYNC]);
  c_ptr: cover property ($rose(eth_pointer_ok_flag_o));
endmodule // crxm_regs_sva

bind crxm_regs crxm_regs_sva #(.BUF_W(BUF_W)) u_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .hyperframe_i(hyperframe_i),
  .hdlc_speed_byte_i(hdlc_speed_byte_i), .eth_pointer_byte_i(eth_pointer_byte_i),
  .buf_fill_i(buf_fill_i), .byte_delay_i(byte_delay_i), .buf_realign_o(buf_realign_o),
  .buf_init_delay_o(buf_init_delay_o), .accepted_hdlc_speed_o(accepted_hdlc_speed_o),
  .hdlc_speed_ok_flag_o(hdlc_speed_ok_flag_o),
  .accepted_eth_pointer_o(accepted_eth_pointer_o),
  .eth_pointer_ok_flag_o(eth_pointer_ok_flag_o),
  .ext_measure_period_o(ext_measure_period_o)
);

//--- crxm_framer_model.sv
/* behavioural receive framer: hyperframe pulses with control bytes,
   radio frame pulses and elastic buffer status.
   assumes: tasks called just after a rising edge of clk_i. */
`timescale 1ns/1ps

module crxm_framer_model #(
  parameter BUF_W = 4
) (
  input wire clk_i,
  output reg hyperframe_o,
  output reg [2:0] speed_o,
  output reg [5:0] pointer_o,
  output reg [BUF_W-1:0] fill_o,
  output reg [1:0] byte_delay_o,
  output reg tx_pulse_o,
  output reg rx_pulse_o
);
  int gap;

  initial begin
    hyperframe_o = 1'b0;
    speed_o = 3'h0;
    pointer_o = 6'h00;
    fill_o = '0;
    byte_delay_o = 2'h0;
    tx_pulse_o = 1'b0;
    rx_pulse_o = 1'b0;
    gap = 1;
  end

  // bytes carry meaning only with the pulse, so they flip in between
  task automatic send_hf(input [2:0] s, input [5:0] p);
    hyperframe_o <= 1'b1;
    speed_o <= s;
    pointer_o <= p;
    @(posedge clk_i);
    hyperframe_o <= 1'b0;
    speed_o <= ~s;
    pointer_o <= ~p;
    repeat (gap) @(posedge clk_i);
  endtask

  task automatic round_trip(input int n);
    tx_pulse_o <= 1'b1;
    @(posedge clk_i);
    tx_pulse_o <= 1'b0;
    repeat (n - 1) @(posedge clk_i);
    rx_pulse_o <= 1'b1;
    @(posedge clk_i);
    rx_pulse_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic set_buf(input [BUF_W-1:0] f, input [1:0] b);
    fill_o <= f;
    byte_delay_o <= b;
    @(posedge clk_i);
  endtask
endmodule // crxm_framer_model

//--- crxm_regs_test.sv
/* self-checking bench for crxm_regs against an integer model.
   assumes: checker bound to crxm_regs, framer model on the far side. */
`timescale 1ns/1ps
`include "crxm_defs.vh"

module crxm_regs_test;
  localparam BW = 4;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [31:0] rdata;
  wire hf, txp, rxp, realign, sok, pok, irq;
  wire [2:0] sb, spd;
  wire [5:0] pb, ptr;
  wire [BW-1:0] fill, idly;
  wire [1:0] bd;
  wire [8:0] ext;
  int seed, fails, checked, m_spd, m_sok, m_ptr, m_pok, c, d, v, n_ra;
  int sq[$];
  int pq[$];

  always #25 clk_i = ~clk_i;

  // a realign pulse is one cycle wide, so one count per request
  always @(negedge clk_i) begin
    if (realign === 1'b1) begin
      n_ra = n_ra + 1;
    end
  end

  crxm_regs #(.BUF_W(BW)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .hyperframe_i(hf), .hdlc_speed_byte_i(sb), .eth_pointer_byte_i(pb),
    .buf_fill_i(fill), .byte_delay_i(bd), .buf_realign_o(realign),
    .buf_init_delay_o(idly), .tx_frame_pulse_i(txp), .rx_frame_pulse_i(rxp),
    .accepted_hdlc_speed_o(spd), .hdlc_speed_ok_flag_o(sok),
    .accepted_eth_pointer_o(ptr), .eth_pointer_ok_flag_o(pok),
    .ext_measure_period_o(ext), .irq_o(irq));
  crxm_framer_model #(.BUF_W(BW)) fm (.clk_i(clk_i), .hyperframe_o(hf), .speed_o(sb),
    .pointer_o(pb), .fill_o(fill), .byte_delay_o(bd), .tx_pulse_o(txp), .rx_pulse_o(rxp));

  task automatic chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input [7:0] a, input [31:0] dat);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rreg(input [7:0] a, input [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    chk(rdata, exp);
    @(posedge clk_i);
  endtask

  // last four pulses decide; invalid codes never enter the model
  task automatic feed(input int s, input int p);
    fm.send_hf(s[2:0], p[5:0]);
    sq.push_back(s);
    pq.push_back(p);
    if (sq.size() > 4) begin
      void'(sq.pop_front());
      void'(pq.pop_front());
    end
    if (sq.size() == 4 && sq[0] == s && sq[1] == s && sq[2] == s && s <= 5) begin
      m_spd = s;
      m_sok = 1;
    end
    if (sq.size() == 4 && pq[0] == p && pq[1] == p && pq[2] == p && p >= 36) begin
      m_ptr = p;
      m_pok = 1;
    end
  endtask

  function automatic int stat();
    return (m_sok << 11) | (m_spd << 8) | (m_pok << 6) | m_ptr;
  endfunction

  task results;
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fails = fails + 1;
    results;
  end

  initial begin
    seed = 63;
    {fails, checked, m_spd, m_sok, m_ptr, m_pok} = '0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rreg(`CRXM_OFF_MGMT_STATUS, 0);
    rreg(`CRXM_OFF_DELAY_CTRL, 1 << (BW - 1));
    rreg(`CRXM_OFF_ROUND_TRIP, 0);
    rreg(8'h10, 0);
    v = $random(seed);
    wreg(`CRXM_OFF_EXT_SETUP, v);
    rreg(`CRXM_OFF_EXT_SETUP, v & 32'h0000_01ff);
    chk(ext, v & 32'h0000_01ff);
    v = $random(seed);
    fm.set_buf(v[BW-1:0], v[9:8]);
    rreg(`CRXM_OFF_FILL_STATUS, (v[BW-1:0] << 2) | v[9:8]);
    d = $random(seed) & ((1 << BW) - 1);
    wreg(`CRXM_OFF_DELAY_CTRL, 32'hfffe_0000 | d);
    chk(idly, 1 << (BW - 1));
    chk(n_ra, 0);
    rreg(`CRXM_OFF_DELAY_CTRL, d);
    wreg(`CRXM_OFF_DELAY_CTRL, 32'h0001_0000 | d);
    chk(idly, d);
    chk(n_ra, 1);
    for (c = 0; c < 8; c++) begin
      fm.gap = (c % 2) ? 9 : 1;
      repeat (3) feed(c, 34 + c);
      feed(7, 0);
      repeat (4) feed(c, 34 + c);
      rreg(`CRXM_OFF_MGMT_STATUS, stat());
      chk({sok, spd, 1'b0, pok, ptr}, stat());
    end
    wreg(`CRXM_OFF_MGMT_SETUP, 32'h0003_0330);
    {m_spd, m_ptr} = {32'd3, 32'h30};
    rreg(`CRXM_OFF_MGMT_STATUS, stat());
    wreg(`CRXM_OFF_MGMT_SETUP, 32'h0002_0010);
    rreg(`CRXM_OFF_MGMT_STATUS, stat());
    foreach (sq[i]) begin
      fm.round_trip(1 + sq[i] * 9);
      rreg(`CRXM_OFF_ROUND_TRIP, 1 + sq[i] * 9);
    end
    wreg(`CRXM_OFF_IRQ_MASK, 0);
    rreg(`CRXM_OFF_IRQ_STATUS, 32'h0000_000f);
    wreg(`CRXM_OFF_IRQ_STATUS, 32'h0000_000f);
    fm.round_trip(5);
    wreg(`CRXM_OFF_DELAY_CTRL, 32'h0001_0000 | d);
    chk(n_ra, 2);
    // realign status bit lands three edges after the write strobe
    @(posedge clk_i);
    rreg(`CRXM_OFF_IRQ_STATUS, 32'h0000_000c);
    chk(irq, 0);
    wreg(`CRXM_OFF_IRQ_MASK, 32'h0000_0004);
    chk(irq, 1);
    wreg(`CRXM_OFF_IRQ_STATUS, 32'h0000_0004);
    rreg(`CRXM_OFF_IRQ_STATUS, 32'h0000_0008);
    chk(irq, 0);
    results;
  end
endmodule // crxm_regs_test
